// ---- design/slpm_pkg.sv ----
`default_nettype none
package slpm_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int PARTIAL_EXIT_NS  = 10;
    localparam int SLUMBER_EXIT_MS  = 10;
    localparam int DEVSLP_EXIT_MS   = 20;
    localparam int PARTIAL_EXIT_CYC =
        (PARTIAL_EXIT_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
        (PARTIAL_EXIT_NS * 1000 / CLK_PERIOD_PS);
    localparam int SLUMBER_EXIT_CYC =
        int'(64'(SLUMBER_EXIT_MS) * 64'd1000000000 / 64'(CLK_PERIOD_PS));
    localparam int DEVSLP_EXIT_CYC  =
        int'(64'(DEVSLP_EXIT_MS) * 64'd1000000000 / 64'(CLK_PERIOD_PS));

    // ----------------------------------------------------------------
    // configuration field
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG_OVERRIDE_OFS = 8'h9c;
    localparam int         CFG_OVERRIDE_BIT = 7;

    // ----------------------------------------------------------------
    // link power states, gray along active-partial-slumber-devslp
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SLPM_ACTIVE  = 3'h0,
        SLPM_PARTIAL = 3'h1,
        SLPM_SLUMBER = 3'h3,
        SLPM_DEVSLP  = 3'h2,
        SLPM_WAKING  = 3'h6
    } slpm_link_e;

endpackage : slpm_pkg
`default_nettype wire

// ---- design/slpm_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module slpm_port #(
    parameter int SLUMBER_CYC = slpm_pkg::SLUMBER_EXIT_CYC,
    parameter int DEVSLP_CYC  = slpm_pkg::DEVSLP_EXIT_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d3_i,
    input  wire logic pm_partial_req_i,
    input  wire logic pm_slumber_req_i,
    input  wire logic devslp_req_i,
    input  wire logic cable_req_i,
    input  wire logic rx_comwake_i,
    input  wire logic link_up_i,
    output logic      pm_ack_o,
    output logic      comwake_o,
    output logic      devslp_o,
    output logic      link_ready_o,
    output logic      wake_timeout_o,
    output logic [2:0] link_state_o
);
    localparam int TW = $clog2(DEVSLP_CYC + 1);

    slpm_pkg::slpm_link_e st_ff, nxt_st;
    slpm_pkg::slpm_link_e from_ff, nxt_from;
    logic [TW-1:0]        tmr_ff, nxt_tmr;
    logic                 ack_ff, nxt_ack;
    logic                 cw_ff, nxt_cw;
    logic                 to_ff, nxt_to;
    logic [TW-1:0]        limit;

    // ----------------------------------------------------------------
    // link state record
    // ----------------------------------------------------------------
    always_comb begin
        case (from_ff)
            slpm_pkg::SLPM_PARTIAL: limit = TW'(slpm_pkg::PARTIAL_EXIT_CYC);
            slpm_pkg::SLPM_SLUMBER: limit = TW'(SLUMBER_CYC);
            default:                limit = TW'(DEVSLP_CYC);
        endcase
    end

    always_comb begin
        nxt_st   = st_ff;
        nxt_from = from_ff;
        nxt_tmr  = tmr_ff;
        nxt_ack  = 1'b0;
        nxt_cw   = 1'b0;
        nxt_to   = to_ff;
        if (d3_i) begin
            nxt_st = st_ff;
        end else begin
            case (st_ff)
                slpm_pkg::SLPM_ACTIVE: begin
                    if (pm_partial_req_i || pm_slumber_req_i) begin
                        nxt_ack = 1'b1;
                        nxt_st  = pm_slumber_req_i ? slpm_pkg::SLPM_SLUMBER
                                                   : slpm_pkg::SLPM_PARTIAL;
                    end
                end
                slpm_pkg::SLPM_PARTIAL, slpm_pkg::SLPM_SLUMBER: begin
                    if (st_ff == slpm_pkg::SLPM_SLUMBER && devslp_req_i) begin
                        nxt_st = slpm_pkg::SLPM_DEVSLP;
                    end else if (cable_req_i || rx_comwake_i) begin
                        nxt_cw   = cable_req_i;
                        // keep the longer device sleep budget
                        if (from_ff != slpm_pkg::SLPM_DEVSLP) begin
                            nxt_from = st_ff;
                        end
                        nxt_tmr  = '0;
                        nxt_st   = slpm_pkg::SLPM_WAKING;
                    end
                end
                slpm_pkg::SLPM_DEVSLP: begin
                    if (!devslp_req_i) begin
                        nxt_st   = slpm_pkg::SLPM_SLUMBER;
                        nxt_from = slpm_pkg::SLPM_DEVSLP;
                    end
                end
                slpm_pkg::SLPM_WAKING: begin
                    nxt_tmr = tmr_ff + TW'(1);
                    if (link_up_i) begin
                        nxt_st   = slpm_pkg::SLPM_ACTIVE;
                        nxt_from = slpm_pkg::SLPM_SLUMBER;
                        nxt_to   = 1'b0;
                    end else if (tmr_ff >= limit) begin
                        nxt_to  = 1'b1;
                        nxt_cw  = 1'b1;
                        nxt_tmr = '0;
                    end
                end
                default: nxt_st = slpm_pkg::SLPM_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff   <= slpm_pkg::SLPM_ACTIVE;
            from_ff <= slpm_pkg::SLPM_SLUMBER;
            tmr_ff  <= '0;
            ack_ff  <= 1'b0;
            cw_ff   <= 1'b0;
            to_ff   <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            from_ff <= nxt_from;
            tmr_ff  <= nxt_tmr;
            ack_ff  <= nxt_ack;
            cw_ff   <= nxt_cw;
            to_ff   <= nxt_to;
        end
    end

    assign pm_ack_o       = ack_ff;
    assign comwake_o      = cw_ff;
    assign devslp_o       = (st_ff == slpm_pkg::SLPM_DEVSLP);
    assign link_ready_o   = (st_ff == slpm_pkg::SLPM_ACTIVE) && !d3_i;
    assign wake_timeout_o = to_ff;
    assign link_state_o   = st_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
        (!d3_i && st_ff == slpm_pkg::SLPM_ACTIVE && pm_partial_req_i)
        |=> pm_ack_o)
        else $error("drive request not acknowledged");
    a_no_self_lpm: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff == slpm_pkg::SLPM_ACTIVE &&
         nxt_st inside {slpm_pkg::SLPM_PARTIAL, slpm_pkg::SLPM_SLUMBER})
        |-> (pm_partial_req_i || pm_slumber_req_i))
        else $error("host started a power transition");
    a_wake_comwake: assert property (@(posedge clk_i) disable iff (rst_i)
        (!d3_i && cable_req_i && !devslp_req_i &&
         st_ff inside {slpm_pkg::SLPM_PARTIAL, slpm_pkg::SLPM_SLUMBER})
        |=> comwake_o && st_ff == slpm_pkg::SLPM_WAKING)
        else $error("no comwake before cable use");
    a_devslp_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(devslp_o) |-> $past(st_ff) == slpm_pkg::SLPM_SLUMBER)
        else $error("device sleep entered outside slumber");
    a_devslp_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(devslp_o) |-> st_ff == slpm_pkg::SLPM_SLUMBER)
        else $error("device sleep exit not to slumber");
    a_d3_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        d3_i ##1 d3_i |-> $stable(st_ff))
        else $error("link state lost in low power state");
endmodule : slpm_port
`default_nettype wire

// ---- design/slpm_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module slpm_top #(
    parameter int NPORTS      = 6,
    parameter int SLUMBER_CYC = slpm_pkg::SLUMBER_EXIT_CYC,
    parameter int DEVSLP_CYC  = slpm_pkg::DEVSLP_EXIT_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              d3_i,
    input  wire logic              raid_mode_i,
    input  wire logic              ahci_enable_override_i,
    input  wire logic              acc_valid_i,
    input  wire logic [1:0]        acc_space_i,
    input  wire logic              irq_pending_i,
    input  wire logic [NPORTS-1:0] pm_partial_req_i,
    input  wire logic [NPORTS-1:0] pm_slumber_req_i,
    input  wire logic [NPORTS-1:0] devslp_req_i,
    input  wire logic [NPORTS-1:0] cable_req_i,
    input  wire logic [NPORTS-1:0] rx_comwake_i,
    input  wire logic [NPORTS-1:0] link_up_i,
    output logic                   acc_accept_o,
    output logic                   acc_abort_o,
    output logic                   irq_o,
    output logic                   raid_avail_o,
    output logic [NPORTS-1:0]      phy_enable_o,
    output logic [NPORTS-1:0]      dev_present_o,
    output logic [NPORTS-1:0]      pm_ack_o,
    output logic [NPORTS-1:0]      comwake_o,
    output logic [NPORTS-1:0]      devslp_o,
    output logic [NPORTS-1:0]      link_ready_o,
    output logic [NPORTS-1:0]      wake_timeout_o,
    output logic [3*NPORTS-1:0]    link_state_o
);
    // acc_space_i: 0 configuration, 1 memory, 2 I/O
    logic acc_ok_ff, nxt_acc_ok;
    logic acc_ab_ff, nxt_acc_ab;
    logic irq_ff,    nxt_irq;
    logic raid_ff,   nxt_raid;

    // ----------------------------------------------------------------
    // function power state gating and raid override gating
    // ----------------------------------------------------------------
    always_comb begin
        nxt_acc_ok = acc_valid_i && (!d3_i || acc_space_i == 2'h0);
        nxt_acc_ab = acc_valid_i && d3_i && acc_space_i != 2'h0;
        nxt_irq    = irq_pending_i && !d3_i;
        nxt_raid   = raid_mode_i && !ahci_enable_override_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ok_ff <= 1'b0;
            acc_ab_ff <= 1'b0;
            irq_ff    <= 1'b0;
            raid_ff   <= 1'b0;
        end else begin
            acc_ok_ff <= nxt_acc_ok;
            acc_ab_ff <= nxt_acc_ab;
            irq_ff    <= nxt_irq;
            raid_ff   <= nxt_raid;
        end
    end

    assign acc_accept_o  = acc_ok_ff;
    assign acc_abort_o   = acc_ab_ff;
    assign irq_o         = irq_ff;
    assign raid_avail_o  = raid_ff;
    assign phy_enable_o  = {NPORTS{!d3_i}};
    assign dev_present_o = link_up_i & {NPORTS{!d3_i}};

    // ----------------------------------------------------------------
    // per-port link power record
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        slpm_port #(
            .SLUMBER_CYC (SLUMBER_CYC),
            .DEVSLP_CYC  (DEVSLP_CYC)
        ) u_port (
            .clk_i            (clk_i),
            .rst_i            (rst_i),
            .d3_i             (d3_i),
            .pm_partial_req_i (pm_partial_req_i[p]),
            .pm_slumber_req_i (pm_slumber_req_i[p]),
            .devslp_req_i     (devslp_req_i[p]),
            .cable_req_i      (cable_req_i[p]),
            .rx_comwake_i     (rx_comwake_i[p]),
            .link_up_i        (link_up_i[p]),
            .pm_ack_o         (pm_ack_o[p]),
            .comwake_o        (comwake_o[p]),
            .devslp_o         (devslp_o[p]),
            .link_ready_o     (link_ready_o[p]),
            .wake_timeout_o   (wake_timeout_o[p]),
            .link_state_o     (link_state_o[3*p +: 3])
        );
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_d3_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (d3_i && acc_valid_i && acc_space_i != 2'h0)
        |=> acc_abort_o && !acc_accept_o)
        else $error("d3 memory or io access not aborted");
    a_d3_cfg_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_valid_i && acc_space_i == 2'h0) |=> acc_accept_o)
        else $error("configuration access refused");
    a_d3_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(d3_i) |-> !irq_o)
        else $error("interrupt raised in d3");
    a_irq_d0: assert property (@(posedge clk_i) disable iff (rst_i)
        (!d3_i && irq_pending_i) |=> irq_o)
        else $error("pending interrupt not raised in d0");
    a_raid_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (raid_mode_i && ahci_enable_override_i) |=> !raid_avail_o)
        else $error("raid available with override set");
    a_d3_phy_off: assert property (@(posedge clk_i) disable iff (rst_i)
        d3_i |-> (phy_enable_o == '0 && dev_present_o == '0))
        else $error("port powered in d3");
endmodule : slpm_top
`default_nettype wire

// ---- test/slpm_drive.sv ----
`timescale 1ns/10ps
`default_nettype none
module slpm_drive #(
    parameter int N   = 2,
    parameter int LAT = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] want_p_i,
    input  wire logic [N-1:0] want_s_i,
    input  wire logic [N-1:0] mute_i,
    input  wire logic [N-1:0] wake_i,
    input  wire logic [N-1:0] comwake_i,
    output logic      [N-1:0] part_req_o,
    output logic      [N-1:0] slum_req_o,
    output logic      [N-1:0] rx_wake_o,
    output logic      [N-1:0] link_up_o
);
    logic [7:0] cnt_ff [N];
    assign part_req_o = want_p_i;
    assign slum_req_o = want_s_i;
    // drive wakes the link only when asked, never while idle
    assign rx_wake_o  = wake_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        for (int i = 0; i < N; i++) begin
            if (rst_i) begin
                link_up_o[i] <= 1'b1;
                cnt_ff[i]    <= 8'h00;
            end else if (want_p_i[i] | want_s_i[i]) begin
                link_up_o[i] <= 1'b0;
            end else if ((comwake_i[i] | wake_i[i]) & ~mute_i[i]) begin
                cnt_ff[i]    <= 8'(LAT - 1);
                link_up_o[i] <= 1'(LAT <= 1);
            end else if (cnt_ff[i] == 8'h01) begin
                link_up_o[i] <= 1'b1;
                cnt_ff[i]    <= 8'h00;
            end else if (cnt_ff[i] != 8'h00) begin
                cnt_ff[i] <= cnt_ff[i] - 8'h01;
            end
        end
    end
endmodule : slpm_drive
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int NP = 2;
    localparam int SC = 20;
    localparam int DC = 40;
    logic            clk_i, rst_i, d3, rm, ovr, av, ip, acc, abt, irq, ravl;
    logic [1:0]      sp;
    logic [NP-1:0]   wp, ws, mute, dw, dsr, cr, preq, sreq, rxw, lup;
    logic [NP-1:0]   pe, dp, ack, cw, ds, rdy, wto;
    logic [3*NP-1:0] st;
    logic [31:0]     lf;
    int              failures, samples_checked, p, n;

    slpm_top #(.NPORTS(NP), .SLUMBER_CYC(SC), .DEVSLP_CYC(DC)) u_dut (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .d3_i                   (d3),
        .raid_mode_i            (rm),
        .ahci_enable_override_i (ovr),
        .acc_valid_i            (av),
        .acc_space_i            (sp),
        .irq_pending_i          (ip),
        .pm_partial_req_i       (preq),
        .pm_slumber_req_i       (sreq),
        .devslp_req_i           (dsr),
        .cable_req_i            (cr),
        .rx_comwake_i           (rxw),
        .link_up_i              (lup),
        .acc_accept_o           (acc),
        .acc_abort_o            (abt),
        .irq_o                  (irq),
        .raid_avail_o           (ravl),
        .phy_enable_o           (pe),
        .dev_present_o          (dp),
        .pm_ack_o               (ack),
        .comwake_o              (cw),
        .devslp_o               (ds),
        .link_ready_o           (rdy),
        .wake_timeout_o         (wto),
        .link_state_o           (st)
    );
    slpm_drive #(.N(NP), .LAT(1)) u_drive (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .want_p_i   (wp),
        .want_s_i   (ws),
        .mute_i     (mute),
        .wake_i     (dw),
        .comwake_i  (cw),
        .part_req_o (preq),
        .slum_req_o (sreq),
        .rx_wake_o  (rxw),
        .link_up_o  (lup)
    );

    function automatic logic [31:0] nxt_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt_rand
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wait_rdy;
        for (n = 0; n < 60 && rdy[p] !== 1'b1; n++) @(negedge clk_i);
    endtask : wait_rdy
    task automatic pm(input logic [1:0] w, input logic [2:0] e);
        {ws[p], wp[p]} = w;
        @(negedge clk_i);
        ws[p] = 1'b0;
        wp[p] = 1'b0;
        chk(ack[p], 1'b1);
        chk(st[3*p+:3], e);
    endtask : pm
    task automatic wake;
        cr[p] = 1'b1;
        @(negedge clk_i);
        chk(cw[p], 1'b1);
        chk(st[3*p+:3], 3'h6);
        wait_rdy();
        cr[p] = 1'b0;
        chk(st[3*p+:3], 3'h0);
    endtask : wake
    task automatic tmo(input int lim);
        mute[p] = 1'b1;
        cr[p] = 1'b1;
        for (n = 0; n < lim + 10 && wto[p] !== 1'b1; n++) @(negedge clk_i);
        chk(8'(n >= lim - 2 && n <= lim + 2), 8'h01);
        mute[p] = 1'b0;
        wait_rdy();
        chk(wto[p], 1'b0);
        cr[p] = 1'b0;
    endtask : tmo
    task automatic xs(input logic [1:0] s, input logic d);
        d3 = d;
        av = 1'b1;
        sp = s;
        @(negedge clk_i);
        av = 1'b0;
        chk(acc, !d || s == 2'h0);
        chk(abt, d && s != 2'h0);
        chk(irq, ip & !d);
        chk(pe, {NP{!d}});
        chk(dp, lup & {NP{!d}});
        chk(cw | ack, 8'h00);
    endtask : xs
    task automatic print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        #(25 * 8000);
        failures++;
        print_verdict();
    end
    initial begin
        {d3, rm, ovr, av, ip, sp, wp, ws, mute, dw, dsr, cr} = '0;
        lf = 32'h00014cb2;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({2'h0, st}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            lf = nxt_rand(lf);
            p = int'(lf[0]);
            pm(2'h2, 3'h3);
            wake();
            pm(2'h1, 3'h1);
            wake();
            dsr[p] = 1'b1;
            @(negedge clk_i);
            chk(st[3*p+:3], 3'h0);
            pm(2'h3, 3'h3);
            @(negedge clk_i);
            chk(st[3*p+:3], 3'h2);
            chk(ds[p], 1'b1);
            dsr[p] = 1'b0;
            for (n = 0; n < 8 && st[3*p+:3] !== 3'h3; n++) @(negedge clk_i);
            chk(ds[p], 1'b0);
            wake();
        end
        pm(2'h1, 3'h1);
        dw[p] = 1'b1;
        @(negedge clk_i);
        dw[p] = 1'b0;
        chk(st[3*p+:3], 3'h6);
        chk(cw[p], 1'b0);
        wait_rdy();
        chk(st[3*p+:3], 3'h0);
        pm(2'h2, 3'h3);
        tmo(SC);
        pm(2'h1, 3'h1);
        tmo(1);
        pm(2'h2, 3'h3);
        dsr[p] = 1'b1;
        @(negedge clk_i);
        dsr[p] = 1'b0;
        @(negedge clk_i);
        chk(st[3*p+:3], 3'h3);
        tmo(DC);
        pm(2'h2, 3'h3);
        d3 = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(rdy, 8'h00);
        d3 = 1'b0;
        @(negedge clk_i);
        chk(st[3*p+:3], 3'h3);
        wake();
        ip = 1'b1;
        for (int s = 0; s < 3; s++) begin
            xs(2'(s), 1'b0);
            xs(2'(s), 1'b1);
        end
        for (int k = 0; k < 40; k++) begin
            lf = nxt_rand(lf);
            ip = lf[4];
            xs(lf[1:0] == 2'h3 ? 2'h1 : lf[1:0], lf[2]);
        end
        repeat (2) @(negedge clk_i);
        chk(ravl, 8'h00);
        rm = 1'b1;
        for (int o = 0; o < 2; o++) begin
            ovr = 1'(o);
            repeat (2) @(negedge clk_i);
            chk(ravl, !ovr);
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
